// File: tb/bbo_tb_partner.sv
// channel model that offers and accepts bytes on the buffer handshake
`default_nettype none
module bbo_tb_partner (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // bench control
   input  wire logic       load,
   input  wire logic [4:0] n_wr,
   input  wire logic [4:0] n_rd,
   input  wire logic       slow,
   output logic            done,
   // buffer handshake
   input  wire logic       wr_taken,
   input  wire logic       rd_given,
   output logic            wr_avail,
   output logic            rd_room
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] wr_left;
   logic [4:0] rd_left;
   logic [1:0] gap;
   wire        pause = (gap != 2'h0) || (slow && (wr_taken || rd_given));
   // offer withdrawn in the finishing cycle when nothing more is pending
   assign wr_avail = (wr_left > {4'h0, wr_taken}) && !pause;
   assign rd_room  = (rd_left > {4'h0, rd_given}) && !pause;
   assign done     = (wr_left == 5'h00) && (rd_left == 5'h00);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_left <= 5'h00;
         rd_left <= 5'h00;
         gap     <= 2'h0;
      end else if (load) begin
         wr_left <= n_wr;
         rd_left <= n_rd;
         gap     <= 2'h0;
      end else begin
         if (wr_taken && wr_left != 5'h00) wr_left <= wr_left - 5'h01;
         if (rd_given && rd_left != 5'h00) rd_left <= rd_left - 5'h01;
         if (slow && (wr_taken || rd_given)) gap <= 2'h3;
         else if (gap != 2'h0) gap <= gap - 2'h1;
      end
   end
endmodule // bbo_tb_partner
`default_nettype wire

// File: tb/tb_bbo_occupancy.sv
// self-checking bench for the byte buffer occupancy and pointer block
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_bbo_occupancy;
   timeunit 1ns;
   timeprecision 1ps;
   import bbo_pkg::*;
   localparam logic [4:0] P_ORD = 5'h10, P_DOS = 5'h08, P_DIS = 5'h04;
   localparam logic [4:0] P_DRQ = 5'h02, P_END = 5'h01;
   logic        mclk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [4:0]  phs = 5'h00, pnw = 5'h00, pnr = 5'h00;
   logic        pload = 1'b0, pslow = 1'b0, pdone, ack, wr_avail, rd_room;
   logic        wr_taken, rd_given, buf_wr, buf_rd, buf_empty, svc_call, end_svc;
   logic [3:0]  buf_addr, wp = 4'hF, rp = 4'hF;
   logic [4:0]  cnt = 5'h00;
   logic [4:0]  log[$];
   int          mismatches = 0, cmp_count = 0;
   always #12.5 mclk = ~mclk;
   bbo_occupancy DUT (
      .MCLK(mclk), .RST_B(rst_b), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .ORDOUT_REQ(phs[4]), .DOUT_START(phs[3]), .DIN_START(phs[2]), .DOUT_REQ(phs[1]),
      .SVC_END(phs[0]), .WR_AVAIL(wr_avail), .RD_ROOM(rd_room), .WR_TAKEN(wr_taken),
      .RD_GIVEN(rd_given), .BUF_ADDR(buf_addr), .BUF_WR(buf_wr), .BUF_RD(buf_rd),
      .BUF_EMPTY(buf_empty), .SERVICE_CALL(svc_call), .END_SERVICE(end_svc));
   bbo_tb_partner PEER (
      .mclk(mclk), .rst_b(rst_b), .load(pload), .n_wr(pnw), .n_rd(pnr), .slow(pslow),
      .done(pdone), .wr_taken(wr_taken), .rd_given(rd_given), .wr_avail(wr_avail),
      .rd_room(rd_room));
   // memory strobes with their addresses, read flag on top
   always @(posedge mclk) if (buf_wr === 1'b1 || buf_rd === 1'b1) log.push_back({buf_rd, buf_addr});
   task automatic clk(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n = 0;
      @(posedge mclk);
      req  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 16);
      r = rdat;
      req <= 1'b0;
      we  <= 1'b0;
      if (n >= 16) `CHK("bus answer", 1'b1, ack)
   endtask
   task automatic ph(input logic [4:0] v);
      @(posedge mclk);
      phs <= v;
      @(posedge mclk);
      phs <= 5'h00;
      clk(3);
   endtask
   task automatic order(input logic [1:0] mode);
      wb(1'b1, BBO_OFS_CTRL, {30'h0, mode}, q);
      ph(P_ORD);
      wp = BBO_PTR_INIT;
      rp = BBO_PTR_INIT;
      cnt = 5'h00;
   endtask
   task automatic st(input logic thr, input logic sc, input logic es);
      logic [31:0] s;
      wb(1'b0, BBO_OFS_STATUS, 32'h0, s);
      `CHK("occupancy", ~cnt, s[4:0])
      `CHK("empty bit", cnt == 5'h00, s[8])
      `CHK("empty port", cnt == 5'h00, buf_empty)
      `CHK("threshold", thr, s[9])
      `CHK("service call", sc, svc_call)
      `CHK("end service", es, end_svc)
      `CHK("pointers", {rp, wp}, s[31:24])
   endtask
   task automatic xfer(input logic [4:0] w, input logic [4:0] r, input logic sl,
                       input int ew, input int er);
      int n = 0;
      int gw = 0;
      int gr = 0;
      log.delete();
      @(posedge mclk);
      pload <= 1'b1;
      pnw   <= w;
      pnr   <= r;
      pslow <= sl;
      @(posedge mclk);
      pload <= 1'b0;
      @(posedge mclk);
      while (pdone !== 1'b1 && n < 12 * (ew + er) + 20) begin
         @(posedge mclk);
         n++;
      end
      // withdraw whatever the block refused
      pnw   <= 5'h00;
      pnr   <= 5'h00;
      pload <= 1'b1;
      @(posedge mclk);
      pload <= 1'b0;
      clk(8);
      foreach (log[i]) begin
         if (log[i][4]) begin
            `CHK("read address", rp, log[i][3:0])
            rp++;
            cnt--;
            gr++;
         end else begin
            `CHK("write address", wp, log[i][3:0])
            wp++;
            cnt++;
            gw++;
         end
      end
      `CHK("writes done", ew, gw)
      `CHK("reads done", er, gr)
   endtask
   task automatic t_reset;
      st(1'b0, 1'b0, 1'b0);
      wb(1'b1, BBO_OFS_PTRS, 32'h0, q);
      wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
      wb(1'b0, 4'hC, 32'h0, q);
      `CHK("unmapped read", 32'h0, q)
      wb(1'b0, BBO_OFS_PTRS, 32'h0, q);
      `CHK("pointers read only", 32'h0000_00FF, q)
      xfer(5'h00, 5'h01, 1'b0, 0, 0);
   endtask
   task automatic t_write;
      order(2'h0);
      st(1'b1, 1'b0, 1'b0);
      ph(P_DOS);
      st(1'b1, 1'b1, 1'b0);
      xfer(5'h05, 5'h00, 1'b0, 5, 0);
      ph(P_END);
      st(1'b1, 1'b1, 1'b0);
      xfer(5'h06, 5'h00, 1'b1, 6, 0);
      ph(P_DRQ);
      st(1'b1, 1'b1, 1'b0);
      xfer(5'h01, 5'h00, 1'b0, 1, 0);
      st(1'b0, 1'b1, 1'b0);
      ph(P_DRQ);
      ph(P_END);
      st(1'b0, 1'b0, 1'b1);
      xfer(5'h01, 5'h01, 1'b0, 1, 1);
      `CHK("read wins", 1'b1, log[0][4])
      xfer(5'h00, 5'h02, 1'b0, 0, 2);
      st(1'b1, 1'b1, 1'b1);
      xfer(5'h0A, 5'h00, 1'b0, 6, 0);
      st(1'b0, 1'b1, 1'b1);
      xfer(5'h00, 5'h11, 1'b1, 0, 16);
      st(1'b1, 1'b1, 1'b1);
   endtask
   task automatic t_read;
      order(2'h1);
      ph(P_DIS);
      st(1'b1, 1'b0, 1'b0);
      xfer(5'h03, 5'h00, 1'b0, 3, 0);
      st(1'b1, 1'b0, 1'b0);
      xfer(5'h01, 5'h00, 1'b0, 1, 0);
      st(1'b0, 1'b1, 1'b0);
      xfer(5'h04, 5'h00, 1'b0, 4, 0);
      ph(P_END);
      st(1'b0, 1'b1, 1'b0);
      xfer(5'h01, 5'h07, 1'b1, 1, 7);
      `CHK("write wins", 1'b0, log[0][4])
      st(1'b1, 1'b0, 1'b0);
   endtask
   task automatic t_single;
      order(2'h2);
      ph(P_DOS);
      xfer(5'h0C, 5'h00, 1'b0, 12, 0);
      ph(P_DRQ);
      st(1'b0, 1'b1, 1'b0);
      xfer(5'h02, 5'h00, 1'b0, 2, 0);
      ph(P_DRQ);
      st(1'b0, 1'b1, 1'b1);
   endtask
   initial begin
      clk(3);
      rst_b <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_single();
      test_done();
   end
   initial begin
      clk(20000);
      mismatches++;
      test_done();
   end
endmodule // tb_bbo_occupancy
`default_nettype wire

// File: verilog/bbo_occupancy.sv
// occupancy counter, service flags and buffer pointers with a wishbone slave
//
// The implementer's own choices: the address map and register access over Wishbone.
`default_nettype none
module bbo_occupancy (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // service cycle phases
   input  wire logic        ORDOUT_REQ,
   input  wire logic        DOUT_START,
   input  wire logic        DIN_START,
   input  wire logic        DOUT_REQ,
   input  wire logic        SVC_END,
   // byte producer and consumer
   input  wire logic        WR_AVAIL,
   input  wire logic        RD_ROOM,
   output logic             WR_TAKEN,
   output logic             RD_GIVEN,
   // byte memory control
   output logic      [3:0]  BUF_ADDR,
   output logic             BUF_WR,
   output logic             BUF_RD,
   // flags
   output logic             BUF_EMPTY,
   output logic             SERVICE_CALL,
   output logic             END_SERVICE
);
   import bbo_pkg::*;

   function automatic logic [3:0] addr_inc(input logic [3:0] a);
      addr_inc = a + BBO_PTR_ONE;
   endfunction

   bbo_seq_e    state;
   bbo_seq_e    next_state;
   logic [1:0]  ctrl;
   logic [4:0]  occupancy_counter;
   logic [3:0]  write_pointer;
   logic [3:0]  read_pointer;
   logic [3:0]  addr_latch;
   logic        cyc_is_wr;
   logic        service_threshold_flag;
   logic        service_call_flag;
   logic        end_service_flag;
   logic        data_phase;

   wire read_order    = ctrl[BBO_CTRL_READ_ORDER];
   wire single_byte_interface = ctrl[BBO_CTRL_SINGLE_BYTE];
   wire write_or_checkwrite_order = ~read_order;

   // request and arbitration
   wire buffer_empty        = &occupancy_counter;
   wire buffer_full         = ~occupancy_counter[BBO_OCC_FULL_BIT];
   wire write_cycle_request = WR_AVAIL & ~buffer_full;
   wire read_cycle_request  = RD_ROOM & ~buffer_empty;
   wire seq_idle            = (state == SEQ_IDLE);
   wire start_ok            = seq_idle & ~ORDOUT_REQ;
   wire pick_rd  = read_cycle_request & (~write_cycle_request | write_or_checkwrite_order);
   wire pick_wr  = write_cycle_request & ~pick_rd;
   wire start_cyc           = start_ok & (pick_rd | pick_wr);

   // sequencer step decodes
   wire write_cycle_active  = ~seq_idle & cyc_is_wr;
   wire read_cycle_active   = ~seq_idle & ~cyc_is_wr;
   wire counter_clock       = (state == SEQ_CNT);
   wire write_pointer_hold  = ~(write_cycle_active & (state == SEQ_XFER));
   wire read_pointer_hold   = ~(read_cycle_active & (state == SEQ_XFER));
   wire write_pointer_load  = write_cycle_active & (state == SEQ_LOAD);
   wire read_pointer_load   = read_cycle_active & (state == SEQ_LOAD);

   // threshold logic
   wire [4:0] thr_state = read_order ? BBO_OCC_THR_RD : BBO_OCC_THR_WR;
   wire threshold_state_hit = (occupancy_counter == thr_state);
   wire threshold_gate = read_order ? ~occupancy_counter[BBO_OCC_HALF_BIT]
                                    : (occupancy_counter[BBO_OCC_HALF_BIT] &
                                       service_threshold_flag);
   wire thr_step = counter_clock & data_phase & threshold_state_hit;

   wire [4:0] next_occ = cyc_is_wr ? (occupancy_counter - BBO_OCC_ONE)
                                   : (occupancy_counter + BBO_OCC_ONE);

   logic next_scr;
   always_comb begin
      next_scr = service_threshold_flag;
      if (ORDOUT_REQ) begin
         next_scr = 1'b1;
      end else if (thr_step) begin
         next_scr = read_cycle_active;
      end
   end

   // service call: sets win over clears
   wire scn_set_start = DOUT_START & service_threshold_flag;
   wire scn_set_thr   = thr_step & (read_order ? write_cycle_active
                                               : read_cycle_active);
   wire scn_clr = DIN_START | (SVC_END & ~threshold_gate);
   wire next_scn = (scn_set_start | scn_set_thr) | (service_call_flag & ~scn_clr);
   wire svc_out  = next_scn & ~(read_order & next_scr);

   wire eds_set = DOUT_REQ & ~service_threshold_flag &
                  (~occupancy_counter[BBO_OCC_LOW_BIT] | ~single_byte_interface);
   wire next_eds = eds_set | (end_service_flag & ~ORDOUT_REQ);

   always_comb begin
      case (state)
         SEQ_IDLE: next_state = start_cyc ? SEQ_SEL : SEQ_IDLE;
         SEQ_SEL:  next_state = SEQ_XFER;
         SEQ_XFER: next_state = SEQ_CNT;
         SEQ_CNT:  next_state = SEQ_LOAD;
         SEQ_LOAD: next_state = SEQ_IDLE;
         default:  next_state = SEQ_IDLE;
      endcase
   end

   // sequencer, one buffer cycle per pass
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state     <= SEQ_IDLE;
         cyc_is_wr <= 1'b0;
      end else begin
         state <= next_state;
         if (start_cyc) begin
            cyc_is_wr <= pick_wr;
         end
      end
   end

   // address latch and memory strobes
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         addr_latch <= BBO_PTR_CLEAR;
         BUF_ADDR   <= BBO_PTR_CLEAR;
         BUF_WR     <= 1'b0;
         BUF_RD     <= 1'b0;
      end else begin
         if (state == SEQ_SEL) begin
            addr_latch <= cyc_is_wr ? write_pointer : read_pointer;
            BUF_ADDR   <= cyc_is_wr ? write_pointer : read_pointer;
         end
         BUF_WR <= (state == SEQ_SEL) & cyc_is_wr;
         BUF_RD <= (state == SEQ_SEL) & ~cyc_is_wr;
      end
   end

   // pointers
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         write_pointer <= BBO_PTR_INIT;
         read_pointer  <= BBO_PTR_INIT;
      end else if (ORDOUT_REQ) begin
         write_pointer <= BBO_PTR_INIT;
         read_pointer  <= BBO_PTR_INIT;
      end else begin
         if (!write_pointer_hold) begin
            write_pointer <= BBO_PTR_CLEAR;
         end else if (write_pointer_load) begin
            write_pointer <= addr_inc(addr_latch);
         end
         if (!read_pointer_hold) begin
            read_pointer <= BBO_PTR_CLEAR;
         end else if (read_pointer_load) begin
            read_pointer <= addr_inc(addr_latch);
         end
      end
   end

   // counter and flags
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         occupancy_counter      <= BBO_OCC_EMPTY;
         service_threshold_flag <= 1'b0;
         service_call_flag      <= 1'b0;
         end_service_flag       <= 1'b0;
         data_phase             <= 1'b0;
      end else begin
         if (ORDOUT_REQ) begin
            occupancy_counter <= BBO_OCC_EMPTY;
         end else if (counter_clock) begin
            occupancy_counter <= next_occ;
         end
         if (DOUT_START | DIN_START) begin
            data_phase <= 1'b1;
         end else if (ORDOUT_REQ) begin
            data_phase <= 1'b0;
         end
         service_threshold_flag <= next_scr;
         service_call_flag      <= next_scn;
         end_service_flag       <= next_eds;
      end
   end

   // registered flag and handshake outputs
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         BUF_EMPTY    <= 1'b1;
         SERVICE_CALL <= 1'b0;
         END_SERVICE  <= 1'b0;
         WR_TAKEN     <= 1'b0;
         RD_GIVEN     <= 1'b0;
      end else begin
         BUF_EMPTY    <= ORDOUT_REQ | (counter_clock ? (&next_occ) : buffer_empty);
         SERVICE_CALL <= svc_out;
         END_SERVICE  <= next_eds;
         WR_TAKEN     <= write_pointer_load;
         RD_GIVEN     <= read_pointer_load;
      end
   end

   // wishbone slave
   bbo_status_s status;
   always_comb begin
      status              = '0;
      status.occupancy    = occupancy_counter;
      status.empty        = buffer_empty;
      status.threshold    = service_threshold_flag;
      status.service_call = service_call_flag;
      status.end_service  = end_service_flag;
      status.wr_ptr       = write_pointer;
      status.rd_ptr       = read_pointer;
   end

   wire        wb_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // write lands on the edge where the master sees ack
   wire        wb_wr_ack = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;
   wire        hit_ctl = (WB_ADR_I == BBO_OFS_CTRL);
   wire        hit_st  = (WB_ADR_I == BBO_OFS_STATUS);
   wire        hit_pt  = (WB_ADR_I == BBO_OFS_PTRS);
   wire [31:0] rd_word = hit_ctl ? {30'h0, ctrl} :
                         hit_st  ? status :
                         hit_pt  ? {24'h0, read_pointer, write_pointer} : 32'h0;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
         ctrl     <= BBO_CTRL_RESET;
      end else begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= (wb_req & ~WB_WE_I) ? rd_word : 32'h0;
         if (wb_wr_ack & hit_ctl & WB_SEL_I[0]) begin
            ctrl <= WB_DAT_I[1:0];
         end
      end
   end

   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   chk_empty_blocks_read: assert property (
      (seq_idle & buffer_empty & start_cyc) |=> cyc_is_wr)
      else $error("read cycle started with empty buffer");

   chk_full_blocks_write: assert property (
      (seq_idle & buffer_full & start_cyc) |=> !cyc_is_wr)
      else $error("write cycle started with full buffer");

   chk_wr_count_down: assert property (
      (counter_clock & cyc_is_wr & !ORDOUT_REQ)
      |=> occupancy_counter == $past(occupancy_counter) - 5'h01)
      else $error("write did not count down");

   chk_ordout_init: assert property (
      ORDOUT_REQ |=> (write_pointer == 4'hF) && (read_pointer == 4'hF)
                     && (occupancy_counter == 5'h1F) && service_threshold_flag)
      else $error("order-out init failed");

   chk_ptr_zero_step: assert property (
      (state == SEQ_XFER) & !ORDOUT_REQ ##1 !ORDOUT_REQ [*2]
      |=> (cyc_is_wr ? write_pointer : read_pointer) == addr_inc(addr_latch))
      else $error("pointer load mismatch");

   chk_ptr_cleared: assert property (
      (state == SEQ_XFER) & !ORDOUT_REQ
      |=> (cyc_is_wr ? write_pointer : read_pointer) == 4'h0)
      else $error("pointer not cleared before load");

   chk_arb_priority: assert property (
      (start_cyc & read_cycle_request & write_cycle_request)
      |=> (cyc_is_wr == $past(read_order)))
      else $error("arbitration wrong");

   chk_thr_write_clear: assert property (
      (thr_step & write_cycle_active & !ORDOUT_REQ) |=> !service_threshold_flag)
      else $error("threshold not cleared on write");

   chk_svc_end_keep: assert property (
      (SVC_END & !DIN_START & read_order & !occupancy_counter[BBO_OCC_HALF_BIT] &
       service_call_flag)
      |=> service_call_flag)
      else $error("service call cleared with eight or more bytes");

   chk_cycle_order: assert property (
      (state == SEQ_SEL) |=> (state == SEQ_XFER) ##1 (state == SEQ_CNT)
                             ##1 (state == SEQ_LOAD) ##1 seq_idle)
      else $error("sequencer order broken");

   chk_end_service_set: assert property (
      (DOUT_REQ & !service_threshold_flag &
       (!occupancy_counter[BBO_OCC_LOW_BIT] | !single_byte_interface)) |=> END_SERVICE)
      else $error("end service not set at data request");

   chk_read_call_mask: assert property (
      (read_order & next_scr) |=> !SERVICE_CALL)
      else $error("service call not masked by threshold");

   chk_thr_read_set: assert property (
      (thr_step & read_cycle_active & !ORDOUT_REQ) |=> service_threshold_flag)
      else $error("threshold not set on read");

   chk_empty_output: assert property (
      (counter_clock & !ORDOUT_REQ) |=> (BUF_EMPTY == (&occupancy_counter)))
      else $error("empty output disagrees with counter");

endmodule // bbo_occupancy
`default_nettype wire

// File: verilog/bbo_pkg.sv
// constants and types for the byte buffer occupancy and pointer block
`default_nettype none
package bbo_pkg;
   // wishbone register byte offsets
   localparam logic [3:0] BBO_OFS_CTRL   = 4'h0;
   localparam logic [3:0] BBO_OFS_STATUS = 4'h4;
   localparam logic [3:0] BBO_OFS_PTRS   = 4'h8;
   // control register fields
   localparam int BBO_CTRL_READ_ORDER  = 0;
   localparam int BBO_CTRL_SINGLE_BYTE = 1;
   localparam logic [1:0] BBO_CTRL_RESET = 2'h0;
   // occupancy counter states, ones complement of the byte count
   localparam logic [4:0] BBO_OCC_EMPTY    = 5'h1F;
   localparam logic [4:0] BBO_OCC_THR_WR   = 5'h14;
   localparam logic [4:0] BBO_OCC_THR_RD   = 5'h1C;
   localparam int         BBO_OCC_FULL_BIT = 4;
   localparam int         BBO_OCC_HALF_BIT = 3;
   localparam int         BBO_OCC_LOW_BIT  = 1;
   localparam logic [4:0] BBO_OCC_ONE      = 5'h01;
   // pointer values
   localparam logic [3:0] BBO_PTR_INIT  = 4'hF;
   localparam logic [3:0] BBO_PTR_CLEAR = 4'h0;
   localparam logic [3:0] BBO_PTR_ONE   = 4'h1;
   // buffer cycle sequencer, one state per former delay-line tap
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_SEL  = 3'b001,
      SEQ_XFER = 3'b010,
      SEQ_CNT  = 3'b011,
      SEQ_LOAD = 3'b100
   } bbo_seq_e;
   // status word layout
   typedef struct packed {
      logic [3:0] rd_ptr;
      logic [3:0] wr_ptr;
      logic [11:0] spare;
      logic       end_service;
      logic       service_call;
      logic       threshold;
      logic       empty;
      logic [2:0] zero;
      logic [4:0] occupancy;
   } bbo_status_s;
endpackage
`default_nettype wire
